/* File: lsd_ctrl_model.sv */
// Controller model: serial link, latch pulse and frame alternate
`timescale 1ns/10ps
`default_nettype none
module lsd_ctrl_model (
  // System clock
  input wire logic clk_i,
  // Lines towards the driver
  output logic shift_clk_o,
  output logic data_o,
  output logic dir_o,
  output logic latch_o,
  output logic alt_o
);
  initial
  begin
    shift_clk_o = 1'b1;
    data_o = 1'b0;
    dir_o = 1'b0;
    latch_o = 1'b0;
    alt_o = 1'b0;
  end
  ////////////////////////////////////////
  // clock only within frames
  task automatic put_bit(input logic d, input logic dir);
    data_o = d;
    dir_o = dir;
    #32 shift_clk_o = 1'b0;
    #32 shift_clk_o = 1'b1;
    // No pull on the line, so never leave the last bit standing
    data_o = ~d;
  endtask : put_bit
  // Shift clock stays still during the pulse and well after it
  task automatic pulse_latch();
    @(posedge clk_i) #1 latch_o = 1'b1;
    repeat (30) @(posedge clk_i);
    #1 latch_o = 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse_latch
  task automatic set_alt(input logic a);
    @(posedge clk_i) #1 alt_o = a;
  endtask : set_alt
endmodule : lsd_ctrl_model
`default_nettype wire

/* File: lsd_driver.sv */
// Top of the LCD segment driver: serial chain, latch and level selection
`timescale 1ns/10ps
`default_nettype none
module lsd_driver
  import lsd_pkg::*;
(
  // System clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Serial link from the controller
  input wire logic shift_clk_i,
  input wire logic serial_data_in_i,
  input wire logic direction_select_i,
  output logic serial_data_out_o,
  // Latch and frame control
  input wire logic latch_pulse_i,
  input wire logic frame_alternate_i,
  // Segment drive selections
  output lsd_level_t [NUM_SEG-1:0] segment_outputs_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: runs on falling edges of the controller's shift clock.
  // No reset here: the clock only moves while the controller sends data.
  logic [NUM_SEG-1:0] shift_reg;

  always_ff @(negedge shift_clk_i)
  begin
    if (direction_select_i)
      // input enters at the far end
      shift_reg <= {serial_data_in_i, shift_reg[IDX_LAST:IDX_FIRST+1]};
    else
      shift_reg <= {shift_reg[IDX_LAST-1:IDX_FIRST], serial_data_in_i};
  end

  always_ff @(negedge shift_clk_i)
  begin
    serial_data_out_o <= direction_select_i ? shift_reg[IDX_FIRST] : shift_reg[IDX_LAST];
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: synchronise latch pulse and frame alternate
  logic [SYNC_STAGES-1:0] lp_sync;
  logic [SYNC_STAGES-1:0] alt_sync;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      lp_sync <= '0;
    else
      lp_sync <= {lp_sync[SYNC_STAGES-2:0], latch_pulse_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      alt_sync <= '0;
    else
      alt_sync <= {alt_sync[SYNC_STAGES-2:0], frame_alternate_i};
  end

  wire logic lp_level = lp_sync[SYNC_STAGES-1];
  wire logic alt_level = alt_sync[SYNC_STAGES-1];

  // The shift word crosses as a held bus: the controller stops the shift
  // clock while the latch pulse is high, so the word is stable when sampled.
  // Limitation: a shift edge within two system clocks after the pulse falls
  // may still be seen by the copy.
  logic [NUM_SEG-1:0] latch_reg;

  // write while pulse high, hold while low
  always_ff @(posedge clk_i)
  begin
    if (lp_level)
      latch_reg <= shift_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one selector per latch bit
  for (genvar i = 0; i < NUM_SEG; i++)
  begin : g_seg
    lsd_seg_level u_level (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .data_i(latch_reg[i]),
      .alt_i(alt_level),
      .level_o(segment_outputs_o[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain checks (no reset in that domain)
  property p_shift_high;
    @(negedge shift_clk_i) disable iff (1'b0)
    direction_select_i |=> (shift_reg[IDX_LAST-1:IDX_FIRST] == $past(shift_reg[IDX_LAST:IDX_FIRST+1]));
  endproperty
  a_shift_high: assert property (p_shift_high) else $error("shift toward bit 1 wrong");

  property p_shift_low;
    @(negedge shift_clk_i) disable iff (1'b0)
    !direction_select_i |=> (shift_reg[IDX_LAST:IDX_FIRST+1] == $past(shift_reg[IDX_LAST-1:IDX_FIRST]));
  endproperty
  a_shift_low: assert property (p_shift_low) else $error("shift toward bit 80 wrong");

  property p_entry;
    @(negedge shift_clk_i) disable iff (1'b0)
    1'b1 |=> ((($past(direction_select_i) ? shift_reg[IDX_LAST] : shift_reg[IDX_FIRST]))
              == $past(serial_data_in_i));
  endproperty
  a_entry: assert property (p_entry) else $error("input bit not at chain entry");

  property p_advance;
    @(negedge shift_clk_i) disable iff (1'b0)
    ##1 1'b1 |-> (shift_reg != $past(shift_reg)) || ($past(shift_reg) == {NUM_SEG{$past(serial_data_in_i)}});
  endproperty
  a_advance: assert property (p_advance) else $error("chain did not advance");

  property p_cascade;
    @(negedge shift_clk_i) disable iff (1'b0)
    1'b1 |=> (serial_data_out_o ==
              ($past(direction_select_i) ? $past(shift_reg[IDX_FIRST]) : $past(shift_reg[IDX_LAST])));
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade output wrong");

  // System domain checks
  property p_latch_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    !lp_level ##1 !lp_level |-> $stable(latch_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed while held");

  property p_latch_write;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(latch_pulse_i) ##1 latch_pulse_i[*2] |=> ##1 lp_level;
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch pulse not seen");

  property p_map_ends;
    @(posedge clk_i) disable iff (!resetn_i)
    (latch_reg[IDX_FIRST] != latch_reg[IDX_LAST]) && $stable(latch_reg) ##1 $stable(latch_reg)
      |-> (segment_outputs_o[IDX_FIRST] != segment_outputs_o[IDX_LAST]);
  endproperty
  a_map_ends: assert property (p_map_ends) else $error("segment mapping wrong");

  c_latch: cover property (@(posedge clk_i) disable iff (!resetn_i) $fell(lp_level));
  c_alt: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(alt_level));
  c_dir_h: cover property (@(negedge shift_clk_i) direction_select_i ##1 direction_select_i);
  c_dir_l: cover property (@(negedge shift_clk_i) !direction_select_i ##1 !direction_select_i);

endmodule : lsd_driver
`default_nettype wire

/* File: lsd_driver_tb.sv */
// Self-checking bench for the LCD segment driver
`timescale 1ns/10ps
`default_nettype none
module lsd_driver_tb;
  import lsd_pkg::*;
  logic clk_i;
  logic resetn_i = 1'b0;
  logic sck, sdin, dsel, sdout, latch, alt;
  lsd_level_t [NUM_SEG-1:0] seg;
  int errors = 0;
  int checks = 0;
  int filled = 0;
  logic [NUM_SEG-1:0] shadow;
  logic [NUM_SEG-1:0] held;
  logic [7:0] rnd = 8'h45;
  lsd_ctrl_model i_ctrl (.clk_i(clk_i), .shift_clk_o(sck), .data_o(sdin), .dir_o(dsel),
    .latch_o(latch), .alt_o(alt));
  lsd_driver i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .shift_clk_i(sck),
    .serial_data_in_i(sdin), .direction_select_i(dsel), .serial_data_out_o(sdout),
    .latch_pulse_i(latch), .frame_alternate_i(alt), .segment_outputs_o(seg));
  ////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [2*NUM_SEG-1:0] levels(input logic [NUM_SEG-1:0] b, input logic a);
    levels = '0;
    for (int i = 0; i < NUM_SEG; i++)
      levels[2*i +: 2] = b[i] ? (a ? LSD_LVL_V5 : LSD_LVL_V0) : (a ? LSD_LVL_V3 : LSD_LVL_V2);
  endfunction : levels
  task automatic check(input string what, input logic [2*NUM_SEG-1:0] seen,
    input logic [2*NUM_SEG-1:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  task automatic shift_bit(input logic d, input logic dir);
    logic exp_out;
    exp_out = dir ? shadow[IDX_FIRST] : shadow[IDX_LAST];
    i_ctrl.put_bit(d, dir);
    shadow = dir ? {d, shadow[NUM_SEG-1:1]} : {shadow[NUM_SEG-2:0], d};
    filled++;
    if (filled > NUM_SEG)
      check("serial_data_out", (2*NUM_SEG)'(sdout), (2*NUM_SEG)'(exp_out));
  endtask : shift_bit
  ////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    check("segment_outputs", seg, levels('1, 1'b0));
    #1 resetn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    // Words 0 and 1 are all ones and all zeros; word 2 takes a random direction per bit
    for (int w = 0; w < 8; w++)
    begin
      for (int i = 0; i < NUM_SEG; i++)
      begin
        rnd = lfsr(rnd);
        shift_bit(w == 0 ? 1'b1 : w == 1 ? 1'b0 : rnd[0], w == 2 ? rnd[3] : w[0]);
      end
      i_ctrl.set_alt(rnd[1]);
      repeat (6) @(posedge clk_i);
      if (w > 0)
        check("segment_outputs", seg, levels(held, rnd[1]));
      i_ctrl.pulse_latch();
      held = shadow;
      repeat (2) @(posedge clk_i);
      check("segment_outputs", seg, levels(held, rnd[1]));
    end
    give_verdict();
  end
endmodule : lsd_driver_tb
`default_nettype wire

/* File: lsd_pkg.sv */
// Shared constants and types for the LCD segment shift/latch driver
// Function
// - The shift register advances one position on every falling shift clock edge.
// - One new serial data bit enters the shift register on each falling shift clock edge.
// - With direction select high, data moves from the 80th position toward the 1st.
// - With direction select low, data moves from the 1st position toward the 80th.
// - The serial data input is always the entry of the chain, whatever the direction.
// - The bit leaving the chain end appears on the serial output, in step with the shift clock.
// - Latch pulse high copies the shift register into the latch; low holds the latch.
// - Each segment output follows its own single latch bit, one to one across all positions.
// - Latched 1 selects V5 (alternate high) or V0 (low); latched 0 selects V3 or V2.
package lsd_pkg;

  // Chain geometry: position n of the panel sits at index n-1
  localparam int unsigned NUM_SEG = 80;
  localparam int unsigned IDX_FIRST = 0;
  localparam int unsigned IDX_LAST = NUM_SEG - 1;

  // Drive level selection, one code per segment
  typedef enum logic [1:0] {
    LSD_LVL_V0,
    LSD_LVL_V2,
    LSD_LVL_V3,
    LSD_LVL_V5
  } lsd_level_t;

  // Level shown by every segment while the system clock domain is in reset
  localparam lsd_level_t LEVEL_RESET = LSD_LVL_V0;

  // Synchroniser length for pins that enter the system clock domain
  localparam int unsigned SYNC_STAGES = 2;

endpackage : lsd_pkg

/* File: lsd_seg_level.sv */
// One segment: latched bit and frame alternate select the drive level
`timescale 1ns/10ps
`default_nettype none
module lsd_seg_level
  import lsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Selection inputs
  input wire logic data_i,
  input wire logic alt_i,
  // Registered level
  output lsd_level_t level_o
);

  lsd_level_t next_level;

  always_comb
  begin
    case ({data_i, alt_i})
      2'b11: next_level = LSD_LVL_V5;
      2'b10: next_level = LSD_LVL_V0;
      2'b01: next_level = LSD_LVL_V3;
      default: next_level = LSD_LVL_V2;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      level_o <= LEVEL_RESET;
    else
      level_o <= next_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_sel_on;
    @(posedge clk_i) disable iff (!resetn_i)
    data_i |=> (level_o == ($past(alt_i) ? LSD_LVL_V5 : LSD_LVL_V0));
  endproperty
  a_sel_on: assert property (p_sel_on) else $error("selected level wrong");

  property p_sel_off;
    @(posedge clk_i) disable iff (!resetn_i)
    !data_i |=> (level_o == ($past(alt_i) ? LSD_LVL_V3 : LSD_LVL_V2));
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("non-selected level wrong");

endmodule : lsd_seg_level
`default_nettype wire
